//--- rtl/pbs_sequencer.sv
// Pushbutton on/off power sequencer with processor shutdown handshake
//
// Overview of operation
// - Enable off after reset until valid press
// - Turn on after 32ms plus extension low
// - Turn-on extension adds to fixed 32ms
// - Button high during turn-on restarts qualification
// - 512ms blanking ignores request and button
// - Request still low after blanking aborts
// - Debounce button release 32ms after blanking
// - Low shutdown request releases enable immediately
// - Turn off after 32ms plus extension low
// - Turn-off qualification restarts when button rises
// - Qualified turn-off drives alert low
// - Release enable 1024ms after alert
// - Request low during alert releases, cancels timer
// - Debounce button release 32ms after turn-off
// - Ignore button 256ms after request release
// - Enable polarity selectable by parameter
// - Off state waits for button falling edge
// - Act on request low only after 30us
`timescale 1ns/1ps

module pbs_sequencer
	import pbs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
	parameter logic [MS_W-1:0] TURN_ON_EXTENSION = EXT_NONE,
	parameter logic [MS_W-1:0] TURN_OFF_EXTENSION = EXT_NONE,
	parameter bit ENABLE_ACTIVE_HIGH = 1'b1
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic buttonIn_n,
	input wire logic shutdownReq_n,
	output pbs_od_s enablePin,
	output pbs_od_s alertPin_n,
	output logic powerOn
);

	// Synchronisers, first stage read only by the second
	logic [1:0] buttonSync;
	logic [1:0] killSync;
	logic buttonPrev;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			buttonSync <= SYNC_IDLE;
			killSync <= SYNC_IDLE;
			buttonPrev <= 1'b1;
		end else begin
			buttonSync <= {buttonSync[0], buttonIn_n};
			killSync <= {killSync[0], shutdownReq_n};
			buttonPrev <= buttonSync[1];
		end
	end

	wire logic buttonHigh = buttonSync[1];
	wire logic buttonFell = buttonPrev && !buttonHigh;

	// Request must stay low 30us; board noise on this line is common
	logic [KILL_CNT_W-1:0] killCount;
	logic killLow;
	wire logic killRaw = !killSync[1];
	wire logic killDone = (killCount == KILL_FILT_CYCLES - KILL_CNT_ONE);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			killCount <= KILL_CNT_ZERO;
			killLow <= 1'b0;
		end else if (!killRaw) begin
			killCount <= KILL_CNT_ZERO;
			killLow <= 1'b0;
		end else if (killDone) begin
			killLow <= 1'b1;
		end else begin
			killCount <= killCount + KILL_CNT_ONE;
		end
	end

	// State machine
	pbs_state_e state;
	pbs_state_e next_state;

	// One time base; restarting the prescaler with the state keeps
	// every interval exact to the cycle rather than a tick short
	logic [TICK_CNT_W-1:0] prescale;
	logic [MS_W-1:0] msCount;
	// Release debounce restarts each time the button dips low, so a
	// button still held after blanking never drops power
	wire logic releaseHold = !buttonHigh &&
		((state == PBS_ON_RELEASE) || (state == PBS_OFF_RELEASE));
	wire logic restart = (next_state != state) || releaseHold;
	wire logic msTick = (prescale == TICK_CNT_W'(TICK_CYCLES - 1));

	always_ff @(posedge sys_clk) begin
		if (!resetn || restart) begin
			prescale <= '0;
			msCount <= '0;
		end else if (msTick) begin
			prescale <= '0;
			if (msCount != MS_MAX) begin
				msCount <= msCount + 16'h0001;
			end
		end else begin
			prescale <= prescale + TICK_CNT_W'(1);
		end
	end

	// Interval length that the current state waits for
	wire logic [MS_W-1:0] onTime =
		MS_W'(DEBOUNCE_MS + TURN_ON_EXTENSION);
	wire logic [MS_W-1:0] offTime =
		MS_W'(DEBOUNCE_MS + TURN_OFF_EXTENSION);
	logic [MS_W-1:0] target;
	always_comb begin
		unique case (state)
			PBS_ON_DEBOUNCE: target = onTime;
			PBS_BLANK: target = BLANK_MS;
			PBS_OFF_DEBOUNCE: target = offTime;
			PBS_ALERT: target = ALERT_MS;
			PBS_LOCKOUT: target = LOCKOUT_MS;
			default: target = DEBOUNCE_MS;
		endcase
	end
	wire logic timeUp = (msCount >= target);

	always_comb begin
		next_state = state;
		unique case (state)
			PBS_OFF_IDLE: begin
				if (buttonFell) begin
					next_state = PBS_ON_DEBOUNCE;
				end
			end
			PBS_ON_DEBOUNCE: begin
				if (buttonHigh) begin
					next_state = PBS_OFF_IDLE;
				end else if (timeUp) begin
					next_state = PBS_BLANK;
				end
			end
			PBS_BLANK: begin
				// Button and request are not looked at until the end
				if (timeUp) begin
					if (killLow) begin
						next_state = PBS_OFF_RELEASE;
					end else begin
						next_state = PBS_ON_RELEASE;
					end
				end
			end
			PBS_ON_RELEASE: begin
				if (killLow) begin
					next_state = PBS_LOCKOUT;
				end else if (!buttonHigh) begin
					next_state = PBS_ON_RELEASE;
				end else if (timeUp) begin
					next_state = PBS_ON_RUN;
				end
			end
			PBS_ON_RUN: begin
				if (killLow) begin
					next_state = PBS_LOCKOUT;
				end else if (!buttonHigh) begin
					next_state = PBS_OFF_DEBOUNCE;
				end
			end
			PBS_OFF_DEBOUNCE: begin
				if (killLow) begin
					next_state = PBS_LOCKOUT;
				end else if (buttonHigh) begin
					next_state = PBS_ON_RUN;
				end else if (timeUp) begin
					next_state = PBS_ALERT;
				end
			end
			PBS_ALERT: begin
				if (killLow) begin
					next_state = PBS_LOCKOUT;
				end else if (timeUp) begin
					next_state = PBS_OFF_RELEASE;
				end
			end
			PBS_LOCKOUT: begin
				if (timeUp) begin
					next_state = PBS_OFF_RELEASE;
				end
			end
			PBS_OFF_RELEASE: begin
				if (timeUp) begin
					next_state = PBS_OFF_IDLE;
				end
			end
			default: next_state = PBS_OFF_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= PBS_OFF_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Enable and alert registered so the pins never glitch
	logic enAsserted;
	logic alertAsserted;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			enAsserted <= 1'b0;
			alertAsserted <= 1'b0;
		end else begin
			enAsserted <= pbs_is_on(next_state);
			alertAsserted <= (next_state == PBS_ALERT);
		end
	end

	// Open drain: the high-true variant pulls low while off
	assign enablePin.out = 1'b0;
	assign enablePin.oe = enAsserted ^ ENABLE_ACTIVE_HIGH;
	assign alertPin_n.out = 1'b0;
	assign alertPin_n.oe = alertAsserted;
	assign powerOn = enAsserted;

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// Reset itself is what is watched, so the default disable is lifted
	property p_resetOff;
		@(posedge sys_clk) disable iff (1'b0)
			!resetn |=> !enAsserted && !alertAsserted;
	endproperty
	a_resetOff: assert property (p_resetOff)
		else $error("enable or alert active after reset");

	property p_onQualified;
		$rose(enAsserted) |-> $past(state) == PBS_ON_DEBOUNCE &&
			$past(msCount) >= onTime && !$past(buttonHigh);
	endproperty
	a_onQualified: assert property (p_onQualified)
		else $error("enable asserted without full turn-on press");

	property p_onRestart;
		state == PBS_ON_DEBOUNCE && buttonHigh |=>
			state == PBS_OFF_IDLE && msCount == '0;
	endproperty
	a_onRestart: assert property (p_onRestart)
		else $error("turn-on qualification not restarted");

	property p_blankHolds;
		state == PBS_BLANK && !timeUp |=> enAsserted && !alertAsserted;
	endproperty
	a_blankHolds: assert property (p_blankHolds)
		else $error("enable dropped during blanking");

	property p_abort;
		state == PBS_BLANK && timeUp && killLow |=>
			!enAsserted ##1 !enAsserted;
	endproperty
	a_abort: assert property (p_abort)
		else $error("power-on not aborted");

	property p_killRelease;
		(state == PBS_ON_RUN || state == PBS_ALERT ||
			state == PBS_OFF_DEBOUNCE) && killLow |=>
			!enAsserted && state == PBS_LOCKOUT;
	endproperty
	a_killRelease: assert property (p_killRelease)
		else $error("shutdown request did not release enable");

	property p_alertRaise;
		state == PBS_OFF_DEBOUNCE && timeUp && !killLow && !buttonHigh
			|=> alertAsserted && alertPin_n.oe && enAsserted;
	endproperty
	a_alertRaise: assert property (p_alertRaise)
		else $error("alert not raised after turn-off press");

	property p_alertTimeout;
		state == PBS_ALERT && timeUp && !killLow |=>
			!enAsserted && !alertAsserted;
	endproperty
	a_alertTimeout: assert property (p_alertTimeout)
		else $error("enable not released at power-down timeout");

	property p_lockout;
		state == PBS_LOCKOUT && !timeUp |=>
			state == PBS_LOCKOUT && !enAsserted;
	endproperty
	a_lockout: assert property (p_lockout)
		else $error("lockout left early");

	// Checker-side run length of a low request, saturating
	logic [KILL_CNT_W-1:0] killRun;
	always_ff @(posedge sys_clk) begin
		if (!resetn || !killRaw) begin
			killRun <= KILL_CNT_ZERO;
		end else if (killRun != '1) begin
			killRun <= killRun + KILL_CNT_ONE;
		end
	end

	property p_killFilter;
		$rose(killLow) |-> killRun >= KILL_FILT_CYCLES;
	endproperty
	a_killFilter: assert property (p_killFilter)
		else $error("short shutdown request accepted");

	property p_syncDelay;
		buttonHigh == $past(buttonIn_n, 2);
	endproperty
	a_syncDelay: assert property (p_syncDelay)
		else $error("button synchroniser delay wrong");

	property p_onHoldRelease;
		state == PBS_ON_RELEASE && !buttonHigh && !killLow |=>
			state == PBS_ON_RELEASE && enAsserted && msCount == '0;
	endproperty
	a_onHoldRelease: assert property (p_onHoldRelease)
		else $error("button held after blanking dropped power");

	property p_offHoldRelease;
		state == PBS_OFF_RELEASE && !buttonHigh |=>
			state == PBS_OFF_RELEASE && !enAsserted && msCount == '0;
	endproperty
	a_offHoldRelease: assert property (p_offHoldRelease)
		else $error("turn-off release debounce not restarted");

	property p_idleWaits;
		state == PBS_OFF_IDLE && !buttonFell |=>
			state == PBS_OFF_IDLE && !enAsserted;
	endproperty
	a_idleWaits: assert property (p_idleWaits)
		else $error("idle left without button falling edge");

	property p_alertKill;
		state == PBS_ALERT && killLow |=>
			!enAsserted && !alertAsserted && !alertPin_n.oe;
	endproperty
	a_alertKill: assert property (p_alertKill)
		else $error("request during alert did not end power-down");

endmodule

//--- rtl/pbs_pkg.sv
// Constants, states and pin carriers for the pushbutton power sequencer
package pbs_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_CNT_W = 32;

	// Intervals in milliseconds, counted in ticks of the time base
	localparam int unsigned MS_W = 16;
	localparam logic [MS_W-1:0] DEBOUNCE_MS = 16'h0020;
	localparam logic [MS_W-1:0] BLANK_MS = 16'h0200;
	localparam logic [MS_W-1:0] ALERT_MS = 16'h0400;
	localparam logic [MS_W-1:0] LOCKOUT_MS = 16'h0100;
	localparam logic [MS_W-1:0] MS_MAX = 16'hFFFF;
	localparam logic [MS_W-1:0] EXT_NONE = 16'h0000;

	// Shutdown request glitch filter, least low time
	localparam int unsigned KILL_MIN_NS = 30000;
	localparam int unsigned KILL_FILT_CYCLES_I =
		(KILL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KILL_CNT_W = 12;
	localparam logic [KILL_CNT_W-1:0] KILL_FILT_CYCLES =
		KILL_CNT_W'(KILL_FILT_CYCLES_I);
	localparam logic [KILL_CNT_W-1:0] KILL_CNT_ZERO = 12'h000;
	localparam logic [KILL_CNT_W-1:0] KILL_CNT_ONE = 12'h001;

	// Synchroniser idle level: both inputs rest high
	localparam logic [1:0] SYNC_IDLE = 2'h3;

	typedef enum logic [8:0] {
		PBS_OFF_IDLE = 9'h001,
		PBS_ON_DEBOUNCE = 9'h002,
		PBS_BLANK = 9'h004,
		PBS_ON_RELEASE = 9'h008,
		PBS_ON_RUN = 9'h010,
		PBS_OFF_DEBOUNCE = 9'h020,
		PBS_ALERT = 9'h040,
		PBS_LOCKOUT = 9'h080,
		PBS_OFF_RELEASE = 9'h100
	} pbs_state_e;

	// Open-drain pin: out is the level driven, oe high while pulling
	typedef struct packed {
		logic out;
		logic oe;
	} pbs_od_s;

	function automatic logic pbs_is_on(input pbs_state_e s);
		pbs_is_on = (s == PBS_BLANK) || (s == PBS_ON_RELEASE) ||
			(s == PBS_ON_RUN) || (s == PBS_OFF_DEBOUNCE) ||
			(s == PBS_ALERT);
	endfunction

endpackage

//--- tb/pbs_cpu_model.sv
// Processor model on the far side of the shutdown request line
`timescale 1ns/1ps

module pbs_cpu_model #(
	parameter int BOOT_CYCLES = 100,
	parameter int HOUSE_CYCLES = 500
) (
	input wire logic sys_clk,
	input wire logic powerOn,
	input wire logic alertOe,
	input wire logic bootAck,
	input wire logic alertAck,
	input wire logic alertWired,
	input wire logic killReq,
	output logic shutdownReq_n = 1'b0
);
	int upCnt = 0;
	int alertCnt = 0;

	// An unpowered processor leaves the request line low
	always_ff @(posedge sys_clk) begin
		upCnt <= powerOn ? upCnt + 1 : 0;
		alertCnt <= alertOe ? alertCnt + 1 : 0;
		shutdownReq_n <= powerOn && bootAck && upCnt >= BOOT_CYCLES &&
			!killReq && !(alertAck && alertCnt >= HOUSE_CYCLES) &&
			!(alertWired && alertOe);
	end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the pushbutton power sequencer
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module testbench;
	import pbs_pkg::*;
	localparam int T = 10;
	localparam int ON_C = (32 + 2) * T;
	localparam int OFF_C = (32 + 3) * T;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic buttonIn_n = 1'b1;
	logic shutdownReq_n;
	logic bootAck = 1'b1;
	logic alertAck = 1'b1;
	logic killReq = 1'b0;
	logic alertWired = 1'b0;
	pbs_od_s enablePin;
	pbs_od_s enLowPin;
	pbs_od_s alertPin_n;
	logic powerOn;
	int n_errors = 0;
	int check_count = 0;
	int n;

	pbs_sequencer #(.TICK_CYCLES(T), .TURN_ON_EXTENSION(16'h0002),
		.TURN_OFF_EXTENSION(16'h0003), .ENABLE_ACTIVE_HIGH(1'b1)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .buttonIn_n(buttonIn_n),
		.shutdownReq_n(shutdownReq_n), .enablePin(enablePin),
		.alertPin_n(alertPin_n), .powerOn(powerOn));

	// Same stimulus into the low-true enable variant
	pbs_sequencer #(.TICK_CYCLES(T), .TURN_ON_EXTENSION(16'h0002),
		.TURN_OFF_EXTENSION(16'h0003), .ENABLE_ACTIVE_HIGH(1'b0))
		i_dutLow (.sys_clk(sys_clk), .resetn(resetn),
		.buttonIn_n(buttonIn_n), .shutdownReq_n(shutdownReq_n),
		.enablePin(enLowPin), .alertPin_n(), .powerOn());

	pbs_cpu_model i_cpu (.sys_clk(sys_clk), .powerOn(powerOn),
		.alertOe(alertPin_n.oe), .bootAck(bootAck), .alertAck(alertAck),
		.alertWired(alertWired), .killReq(killReq),
		.shutdownReq_n(shutdownReq_n));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	task automatic results();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Bounded wait; a hang ends the run with a mismatch
	task automatic waitFor(input bit alert, input logic v, input int bound,
		output int k);
		logic s;
		for (k = 0; k < bound; k++) begin
			@(negedge sys_clk);
			s = alert ? alertPin_n.oe : powerOn;
			if (s === v) begin
				@(posedge sys_clk);
				return;
			end
		end
		`CHK(s, v)
		results();
	endtask

	// A short dip first: qualification must restart from the second press
	task automatic powerUp();
		buttonIn_n <= 1'b0;
		cyc(200);
		buttonIn_n <= 1'b1;
		cyc(5);
		buttonIn_n <= 1'b0;
		waitFor(1'b0, 1'b1, ON_C + 20, n);
		`CHK(n >= ON_C && n <= ON_C + 8, 1'b1)
		`CHK(enablePin.oe, 1'b0)
		`CHK(enLowPin.oe, 1'b1)
		buttonIn_n <= 1'b1;
	endtask

	task automatic offPress();
		cyc(5600);
		`CHK(powerOn, 1'b1)
		buttonIn_n <= 1'b0;
		cyc(100);
		buttonIn_n <= 1'b1;
		cyc(5);
		buttonIn_n <= 1'b0;
		waitFor(1'b1, 1'b1, OFF_C + 20, n);
		`CHK(n >= OFF_C && n <= OFF_C + 8, 1'b1)
	endtask

	task automatic sc_reset();
		`CHK(powerOn, 1'b0)
		`CHK(enablePin.oe, 1'b1)
		`CHK(enLowPin.oe, 1'b0)
		`CHK(alertPin_n.oe, 1'b0)
	endtask

	task automatic sc_abort();
		bootAck <= 1'b0;
		powerUp();
		waitFor(1'b0, 1'b0, 5200, n);
		`CHK(n >= 5100 && n <= 5130, 1'b1)
		cyc(400);
	endtask

	// Button stays low through the lockout: no restart may follow
	task automatic sc_alert_kill();
		bootAck <= 1'b1;
		alertAck <= 1'b1;
		powerUp();
		offPress();
		waitFor(1'b0, 1'b0, 3600, n);
		`CHK(n >= 3400 && n <= 3520, 1'b1)
		`CHK(alertPin_n.oe, 1'b0)
		cyc(3500);
		`CHK(powerOn, 1'b0)
		buttonIn_n <= 1'b1;
		cyc(400);
	endtask

	task automatic sc_timeout();
		alertAck <= 1'b0;
		powerUp();
		offPress();
		waitFor(1'b0, 1'b0, 10300, n);
		`CHK(n >= 10200 && n <= 10260, 1'b1)
		buttonIn_n <= 1'b1;
		cyc(400);
	endtask

	task automatic sc_kill();
		powerUp();
		cyc(5600);
		killReq <= 1'b1;
		cyc(1000);
		killReq <= 1'b0;
		cyc(3200);
		`CHK(powerOn, 1'b1)
		killReq <= 1'b1;
		waitFor(1'b0, 1'b0, 3100, n);
		`CHK(n >= 2990 && n <= 3012, 1'b1)
		killReq <= 1'b0;
		buttonIn_n <= 1'b0;
		cyc(400);
		buttonIn_n <= 1'b1;
		cyc(2600);
		`CHK(powerOn, 1'b0)
	endtask

	// Button pressed again during blanking and held past its end, then alert tied to the request line
	task automatic sc_wired();
		alertAck <= 1'b0;
		alertWired <= 1'b1;
		powerUp();
		cyc(200);
		buttonIn_n <= 1'b0;
		cyc(5100);
		`CHK(powerOn, 1'b1)
		buttonIn_n <= 1'b1;
		offPress();
		waitFor(1'b0, 1'b0, 3100, n);
		`CHK(n >= 2990 && n <= 3012, 1'b1)
		`CHK(alertPin_n.oe, 1'b0)
		alertWired <= 1'b0;
		buttonIn_n <= 1'b1;
		cyc(400);
	endtask

	initial begin
		cyc(10);
		resetn <= 1'b1;
		cyc(1);
		sc_reset();
		sc_abort();
		sc_alert_kill();
		sc_timeout();
		sc_kill();
		sc_wired();
		results();
	end
endmodule
